// file: logic/mps_pkg.sv
// Constants shared by the modem power sequencer device end and host end.
// Assumes a single 40 MHz clock on both ends.
`default_nettype none
package mps_pkg;
   localparam int unsigned CLK_HZ             = 40_000_000;
   // Times in milliseconds as specified
   localparam int unsigned SUPPLY_LOW_MS      = 10;
   localparam int unsigned REG_READY_MS       = 2;
   localparam int unsigned RESET_LOW_MS       = 200;
   localparam int unsigned TOGGLE_ON_MS       = 5000;
   localparam int unsigned TOGGLE_OFF_MS      = 3000;
   localparam int unsigned NOTIFY_MS          = 1;
   localparam int unsigned CYC_PER_MS         = CLK_HZ / 1000;
   // Cycle counts (exact multiples, no rounding needed)
   localparam int unsigned SUPPLY_LOW_CYC     = SUPPLY_LOW_MS * CYC_PER_MS;
   localparam int unsigned REG_READY_CYC      = REG_READY_MS * CYC_PER_MS;
   localparam int unsigned RESET_LOW_CYC      = RESET_LOW_MS * CYC_PER_MS;
   localparam int unsigned TOGGLE_ON_CYC      = TOGGLE_ON_MS * CYC_PER_MS;
   localparam int unsigned TOGGLE_OFF_CYC     = TOGGLE_OFF_MS * CYC_PER_MS;
   localparam int unsigned NOTIFY_CYC         = NOTIFY_MS * CYC_PER_MS;
   localparam int unsigned CNT_W              = 32;

   typedef enum logic [2:0] {
      MPS_OFF      = 3'b000,
      MPS_REG_WAIT = 3'b001,
      MPS_ON       = 3'b010,
      MPS_NOTIFY   = 3'b011,
      MPS_NO_REG   = 3'b100
   } mps_dev_state_type;

   typedef enum logic [1:0] {
      MPS_H_IDLE   = 2'b00,
      MPS_H_PULSE  = 2'b01,
      MPS_H_WAIT   = 2'b10
   } mps_host_state_type;
endpackage : mps_pkg
`default_nettype wire

// file: logic/mps_link_if.sv
// Open-drain link between host and modem: three pins plus monitor and aux supply outputs.
// Pins are pulled up inside the modem; a high enable pulls the wire low.
`default_nettype none
interface mps_link_if;
   logic supplyEnableOe;
   logic resetOe;
   logic powerToggleOe;
   logic supplyEnable;
   logic resetLevel;
   logic powerToggle;
   logic power_state_monitor;
   logic aux_supply_out;

   assign supplyEnable = ~supplyEnableOe;
   assign resetLevel   = ~resetOe;
   assign powerToggle  = ~powerToggleOe;

   modport device (
      input  supplyEnable, resetLevel, powerToggle,
      output power_state_monitor, aux_supply_out
   );
   modport host (
      output supplyEnableOe, resetOe, powerToggleOe,
      input  power_state_monitor, aux_supply_out
   );
endinterface : mps_link_if
`default_nettype wire

// file: logic/mps_device.sv
// Modem-side power and reset sequencer.
// Assumes pins arrive asynchronously from the host; internal pull-ups modelled by the interface.
`default_nettype none
// Behaviour
// - host drives pins only open-drain
// - supply low switches regulator off
// - host holds supply low 10ms
// - regulator ready 2ms after release
// - host uses toggle for normal power
// - reset low resets the radio
// - host holds reset low 200ms
// - toggle acts on release only
// - host holds toggle 5s for on
// - host holds toggle 3s for off
// - host waits for monitor before retoggling
// - power-down notifies network first
// - host keeps terminal inputs low at power-on
// - serial command may request power-down
// - host floats terminal inputs at power-down
// - aux supply follows power monitor
module mps_device
   import mps_pkg::*;
#(
   parameter int unsigned REG_READY   = REG_READY_CYC,
   parameter int unsigned TOGGLE_ON   = TOGGLE_ON_CYC,
   parameter int unsigned TOGGLE_OFF  = TOGGLE_OFF_CYC,
   parameter int unsigned NOTIFY      = NOTIFY_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   mps_link_if.device       link,
   input  wire logic        serialOffReq,
   input  wire logic        terminalHigh,
   output logic             regulatorOn,
   output logic             radioReset,
   output logic             networkDetach,
   output logic             radioActive
);
   mps_dev_state_type state;
   logic [1:0]       enSync;
   logic [1:0]       rstSync;
   logic [1:0]       togSync;
   logic             onRelease;
   logic             offRelease;
   logic             enLvl;
   logic             rstLvl;
   logic             togLvl;
   logic             togPrev;
   logic [CNT_W-1:0] holdCnt;
   logic [CNT_W-1:0] stateCnt;
   logic             monitor;

   // Supply enable synchroniser; idles high like the pulled-up pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enSync <= 2'h3;
      end else if (clkEn) begin
         enSync <= {enSync[0], link.supplyEnable};
      end
   end

   // Reset pin synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'h3;
      end else if (clkEn) begin
         rstSync <= {rstSync[0], link.resetLevel};
      end
   end

   // Toggle pin synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         togSync <= 2'h3;
      end else if (clkEn) begin
         togSync <= {togSync[0], link.powerToggle};
      end
   end
   assign enLvl  = enSync[1];
   assign rstLvl = rstSync[1];
   assign togLvl = togSync[1];

   // Release of a low pulse held for at least the given count
   function automatic logic mps_released(input logic             lvl,
                                         input logic             prev,
                                         input logic [CNT_W-1:0] held,
                                         input logic [CNT_W-1:0] limit);
      return lvl && !prev && (held >= limit);
   endfunction : mps_released

   // Previous toggle level; idles high so reset gives no false edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         togPrev <= 1'b1;
      end else if (clkEn) begin
         togPrev <= togLvl;
      end
   end

   // Toggle low time, saturating so a stuck pin cannot wrap
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         holdCnt <= '0;
      end else if (clkEn) begin
         if (togLvl)
            holdCnt <= '0;
         else if (holdCnt != '1)
            holdCnt <= holdCnt + 1'b1;
      end
   end
   assign onRelease  = mps_released(togLvl, togPrev, holdCnt, CNT_W'(TOGGLE_ON));
   assign offRelease = mps_released(togLvl, togPrev, holdCnt, CNT_W'(TOGGLE_OFF));

   // Power state machine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= MPS_REG_WAIT;
         stateCnt <= '0;
      end else if (clkEn) begin
         if (!enLvl) begin
            state    <= MPS_NO_REG;
            stateCnt <= '0;
         end else begin
            stateCnt <= stateCnt + 1'b1;
            unique case (state)
               MPS_NO_REG: begin
                  state    <= MPS_REG_WAIT;
                  stateCnt <= '0;
               end
               MPS_REG_WAIT: begin
                  if (stateCnt >= REG_READY - 1) begin
                     state    <= MPS_OFF;
                     stateCnt <= '0;
                  end
               end
               MPS_OFF: begin
                  if (onRelease) begin
                     state    <= MPS_ON;
                     stateCnt <= '0;
                  end
               end
               MPS_ON: begin
                  if (offRelease || serialOffReq) begin
                     state    <= MPS_NOTIFY;
                     stateCnt <= '0;
                  end
               end
               MPS_NOTIFY: begin
                  if (stateCnt >= NOTIFY - 1 && !terminalHigh) begin
                     state    <= MPS_OFF;
                     stateCnt <= '0;
                  end
               end
               default: begin
                  state    <= MPS_OFF;
                  stateCnt <= '0;
               end
            endcase
         end
      end
   end

   assign monitor = (state == MPS_ON) || (state == MPS_NOTIFY);

   // Regulator enable, dropped at once on supply loss
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regulatorOn <= 1'b0;
      end else if (clkEn) begin
         regulatorOn <= (state != MPS_NO_REG) && enLvl;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         radioReset  <= 1'b1;
         radioActive <= 1'b0;
      end else if (clkEn) begin
         radioReset  <= !rstLvl || (state != MPS_ON && state != MPS_NOTIFY);
         radioActive <= (state == MPS_ON) && rstLvl;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         networkDetach <= 1'b0;
      end else if (clkEn) begin
         networkDetach <= (state == MPS_NOTIFY);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.power_state_monitor <= 1'b0;
         link.aux_supply_out      <= 1'b0;
      end else if (clkEn) begin
         link.power_state_monitor <= monitor;
         link.aux_supply_out      <= monitor;
      end
   end
endmodule : mps_device
`default_nettype wire

// file: logic/mps_host.sv
// Host-side controller driving the modem's open-drain power pins.
// Assumes user requests come from logic on clk; monitor pin is asynchronous.
`default_nettype none
module mps_host
   import mps_pkg::*;
#(
   parameter int unsigned SUPPLY_LOW  = SUPPLY_LOW_CYC,
   parameter int unsigned RESET_LOW   = RESET_LOW_CYC,
   parameter int unsigned TOGGLE_ON   = TOGGLE_ON_CYC,
   parameter int unsigned TOGGLE_OFF  = TOGGLE_OFF_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   mps_link_if.host         link,
   input  wire logic        powerOnReq,
   input  wire logic        powerOffReq,
   input  wire logic        resetReq,
   input  wire logic        cycleReq,
   output logic             busy,
   output logic             modemOn
);
   mps_host_state_type state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] target;
   logic [1:0]       pinSel;
   logic             wantOn;
   logic             monA;
   logic             monB;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         monA <= 1'b0;
         monB <= 1'b0;
      end else if (clkEn) begin
         monA <= link.power_state_monitor;
         monB <= monA;
      end
   end
   assign modemOn = monB;
   assign busy    = (state != MPS_H_IDLE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state  <= MPS_H_IDLE;
         cnt    <= '0;
         target <= '0;
         pinSel <= 2'h0;
         wantOn <= 1'b0;
      end else if (clkEn) begin
         unique case (state)
            MPS_H_IDLE: begin
               cnt <= '0;
               if (powerOnReq && !monB) begin
                  state <= MPS_H_PULSE; pinSel <= 2'h0; target <= TOGGLE_ON; wantOn <= 1'b1;
               end else if (powerOffReq && monB) begin
                  state <= MPS_H_PULSE; pinSel <= 2'h0; target <= TOGGLE_OFF; wantOn <= 1'b0;
               end else if (resetReq) begin
                  state <= MPS_H_PULSE; pinSel <= 2'h1; target <= RESET_LOW;
               end else if (cycleReq) begin
                  state <= MPS_H_PULSE; pinSel <= 2'h2; target <= SUPPLY_LOW;
               end
            end
            MPS_H_PULSE: begin
               cnt <= cnt + 1'b1;
               if (cnt >= target - 1) begin
                  state <= (pinSel == 2'h0) ? MPS_H_WAIT : MPS_H_IDLE;
               end
            end
            MPS_H_WAIT: begin
               if (monB == wantOn)
                  state <= MPS_H_IDLE;
            end
            default: state <= MPS_H_IDLE;
         endcase
      end
   end

   assign link.powerToggleOe  = (state == MPS_H_PULSE) && (pinSel == 2'h0);
   assign link.resetOe        = (state == MPS_H_PULSE) && (pinSel == 2'h1);
   assign link.supplyEnableOe = (state == MPS_H_PULSE) && (pinSel == 2'h2);
endmodule : mps_host
`default_nettype wire

// file: tb/mps_link_asserts.sv
// Checker for the open-drain power link between the host and modem ends.
// Assumes the bench hands in the interface signals by name, with the same counts.
`default_nettype none
module mps_link_asserts #(
   parameter int unsigned SUPPLY_LOW = 10,
   parameter int unsigned RESET_LOW  = 10,
   parameter int unsigned TOGGLE_ON  = 40,
   parameter int unsigned TOGGLE_OFF = 20
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic supplyEnableOe,
   input wire logic resetOe,
   input wire logic powerToggleOe,
   input wire logic supplyEnable,
   input wire logic resetLevel,
   input wire logic powerToggle,
   input wire logic power_state_monitor,
   input wire logic aux_supply_out
);
   logic [31:0] lowCnt;
   logic        togPending;

   // Length of the low pulse now on the pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt <= 32'h0;
      end else if (clkEn) begin
         lowCnt <= (supplyEnableOe | resetOe | powerToggleOe) ? lowCnt + 32'h1 : 32'h0;
      end
   end

   // Toggle issued and monitor not yet moved
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         togPending <= 1'b0;
      end else if ($fell(powerToggleOe)) begin
         togPending <= 1'b1;
      end else if ($changed(power_state_monitor)) begin
         togPending <= 1'b0;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_supplyLen; $fell(supplyEnableOe) |-> lowCnt == SUPPLY_LOW; endproperty
   a_supplyLen: assert property (p_supplyLen) else $error("supply pulse length");
   property p_resetLen; $fell(resetOe) |-> lowCnt == RESET_LOW; endproperty
   a_resetLen: assert property (p_resetLen) else $error("reset pulse length");
   property p_onLen; $fell(powerToggleOe) && !power_state_monitor |-> lowCnt == TOGGLE_ON;
   endproperty
   a_onLen: assert property (p_onLen) else $error("power-on pulse length");
   property p_offLen; $fell(powerToggleOe) && power_state_monitor |-> lowCnt == TOGGLE_OFF;
   endproperty
   a_offLen: assert property (p_offLen) else $error("power-off pulse length");
   property p_noRetoggle;
      $rose(powerToggleOe) |-> !togPending;
   endproperty
   a_noRetoggle: assert property (p_noRetoggle) else $error("toggle before monitor");
   property p_ack; $fell(powerToggleOe) |-> ##[1:200] $changed(power_state_monitor); endproperty
   a_ack: assert property (p_ack) else $error("toggle had no effect");
   property p_onRelease; !powerToggle |-> $stable(power_state_monitor); endproperty
   a_onRelease: assert property (p_onRelease) else $error("state moved while held");
   property p_notify; $fell(powerToggleOe) && power_state_monitor |-> power_state_monitor[*5];
   endproperty
   a_notify: assert property (p_notify) else $error("power-down too early");
   property p_supplyOff; $fell(supplyEnable) |-> ##[1:6] !power_state_monitor; endproperty
   a_supplyOff: assert property (p_supplyOff) else $error("monitor high, supply off");
   property p_resetKeep; !resetLevel |-> $stable(power_state_monitor); endproperty
   a_resetKeep: assert property (p_resetKeep) else $error("reset moved state");
   property p_aux; $changed(power_state_monitor) |-> ##[0:1] aux_supply_out == power_state_monitor;
   endproperty
   a_aux: assert property (p_aux) else $error("aux differs from monitor");
endmodule : mps_link_asserts
`default_nettype wire

// file: tb/mps_bench.sv
// Bench joining the host and modem ends over the open-drain link.
// Assumes shortened hold counts: toggle on 40, off 20, supply and reset 10 cycles.
`default_nettype none
module mps_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       powerOnReq = 1'b0, powerOffReq = 1'b0, resetReq = 1'b0, cycleReq = 1'b0;
   logic       serialOffReq = 1'b0, terminalHigh = 1'b0;
   logic       clkEn = 1'b1;
   localparam int unsigned SUPPLY_LOW = 10;
   localparam int unsigned RESET_LOW  = 10;
   localparam int unsigned TOGGLE_ON  = 40;
   localparam int unsigned TOGGLE_OFF = 20;
   localparam int unsigned REG_READY  = 8;
   localparam int unsigned NOTIFY     = 4;
   logic       busy, modemOn, regulatorOn, radioReset, networkDetach, radioActive;
   int         failures = 0, checked = 0, cycles = 0;
   // Operation in [2:1] (on, off, reset, cycle), expected power state in [0]
   logic [2:0] rows [8] = '{3'h1, 3'h5, 3'h2, 3'h1, 3'h6, 3'h1, 3'h2, 3'h4};
   mps_link_if link ();

   mps_host #(.SUPPLY_LOW(SUPPLY_LOW), .RESET_LOW(RESET_LOW), .TOGGLE_ON(TOGGLE_ON),
      .TOGGLE_OFF(TOGGLE_OFF)) mps_host_inst (
      .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .link(link), .powerOnReq(powerOnReq),
      .powerOffReq(powerOffReq), .resetReq(resetReq), .cycleReq(cycleReq), .busy(busy),
      .modemOn(modemOn));
   mps_device #(.REG_READY(REG_READY), .TOGGLE_ON(TOGGLE_ON), .TOGGLE_OFF(TOGGLE_OFF),
      .NOTIFY(NOTIFY)) mps_device_inst (
      .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .link(link), .serialOffReq(serialOffReq),
      .terminalHigh(terminalHigh), .regulatorOn(regulatorOn), .radioReset(radioReset),
      .networkDetach(networkDetach), .radioActive(radioActive));
   mps_link_asserts mps_link_asserts_inst (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
      .supplyEnableOe(link.supplyEnableOe),
      .resetOe(link.resetOe), .powerToggleOe(link.powerToggleOe),
      .supplyEnable(link.supplyEnable), .resetLevel(link.resetLevel),
      .powerToggle(link.powerToggle), .power_state_monitor(link.power_state_monitor),
      .aux_supply_out(link.aux_supply_out));

   always #12.5 clk = ~clk;

   task automatic chk(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic pulseReq(input logic [1:0] op);
      @(negedge clk);
      {cycleReq, resetReq, powerOffReq, powerOnReq} = 4'(4'h1 << op);
      @(negedge clk);
      {cycleReq, resetReq, powerOffReq, powerOnReq} = 4'h0;
   endtask : pulseReq

   task automatic waitIdle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 500) begin
         @(negedge clk);
         n++;
      end
      if (n == 500) chk(busy, 1'b0);
      repeat (20) @(negedge clk);
   endtask : waitIdle

   task automatic doOp(input logic [1:0] op);
      pulseReq(op);
      repeat (6) @(negedge clk);
      if (op == 2'h2) chk(radioReset, 1'b1);
      if (op == 2'h3) chk(regulatorOn, 1'b0);
      waitIdle();
   endtask : doOp

   task automatic print_verdict;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         print_verdict();
      end
   end

   initial begin
      repeat (10) @(negedge clk);
      chk(link.power_state_monitor, 1'b0);
      chk(radioReset, 1'b1);
      chk(busy, 1'b0);
      rst_n = 1'b1;
      repeat (20) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         doOp(rows[i][2:1]);
         chk(modemOn, rows[i][0]);
         chk(link.power_state_monitor, rows[i][0]);
         chk(link.aux_supply_out, rows[i][0]);
         chk(regulatorOn, 1'b1);
      end
      // Off request while the power-on is in flight is dropped
      pulseReq(2'h0);
      pulseReq(2'h1);
      waitIdle();
      chk(modemOn, 1'b1);
      // Terminal inputs held high stall the power-down
      terminalHigh = 1'b1;
      pulseReq(2'h1);
      repeat (30) @(negedge clk);
      chk(networkDetach, 1'b1);
      chk(link.power_state_monitor, 1'b1);
      terminalHigh = 1'b0;
      waitIdle();
      chk(link.power_state_monitor, 1'b0);
      doOp(2'h0);
      @(negedge clk);
      serialOffReq = 1'b1;
      @(negedge clk);
      serialOffReq = 1'b0;
      repeat (30) @(negedge clk);
      chk(link.power_state_monitor, 1'b0);
      // Clock enable low freezes a power-on pulse in flight
      pulseReq(2'h0);
      clkEn = 1'b0;
      repeat (100) @(negedge clk);
      chk(link.powerToggleOe, 1'b1);
      chk(busy, 1'b1);
      clkEn = 1'b1;
      waitIdle();
      chk(modemOn, 1'b1);
      // Reset in mid-run returns both ends to off and idle
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      chk(link.power_state_monitor, 1'b0);
      chk(busy, 1'b0);
      rst_n = 1'b1;
      repeat (20) @(negedge clk);
      doOp(2'h0);
      chk(modemOn, 1'b1);
      chk(link.aux_supply_out, 1'b1);
      print_verdict();
   end
endmodule : mps_bench
`default_nettype wire
